// [common/isr_pkg.sv]
// Package for the instrument status reporting block
// Notes on behaviour
// - Status flag is OR of status byte bits ANDed with poll mask bits.
// - Poll mask includes status byte bit 6, unlike request enable mask.
// - Controller writes and reads the poll mask through set and query commands.
// - Standard event register latches its sources; controller reads it by query.
// - Standard event mask enables the event register; writable and readable.
// - Operation complete bit 0 sets only after all earlier commands finished.
// - Bit 2 sets on read without query or unfetched response overwritten.
// - Bit 3 sets on device-dependent error.
// - Bit 4 sets when a valid command cannot be carried out.
// - Bit 5 sets on undefined or malformed command.
// - Bit 6 sets when local key moves device from remote to manual.
// - Bit 7 sets at power up.
// - Operation register reports actions in condition and since-read in event.
// - Operation condition bit 1 high while sensor initialises.
// - Operation condition bit 4 high while measurement runs.
// - Operation condition bit 5 high while waiting for trigger.
// - Operation condition bit 8 shows battery operation.
// - Operation condition bit 9 high during limit check.
// - Questionable bit 3 on sensor overload, bar-graph limit with external power control, or supply fault.
// - Questionable bit 9 on ratio or forward power threshold alarm.
// - Questionable bit 10 when sensor reports an exceptional condition.
// - Questionable bit 11 when burst period smaller than burst width.
// - Reading an event part returns it then clears it; others keep contents.
// - Summary bit is OR of event AND enable; feeds higher condition.
// - Falling changes gated by negative filter, rising by positive filter.
package isr_pkg;

  localparam int ISR_SEW = 8;
  localparam int ISR_SRW = 16;

  // Standard event bit positions
  localparam int ISR_SE_OPC = 0;
  localparam int ISR_SE_QRY = 2;
  localparam int ISR_SE_DEV = 3;
  localparam int ISR_SE_EXE = 4;
  localparam int ISR_SE_CMD = 5;
  localparam int ISR_SE_USR = 6;
  localparam int ISR_SE_PON = 7;

  // Operation condition bit positions
  localparam int ISR_OP_SETTING = 1;
  localparam int ISR_OP_MEASURING = 4;
  localparam int ISR_OP_TRIGGER_WAIT = 5;
  localparam int ISR_OP_BATTERY = 8;
  localparam int ISR_OP_LIMIT = 9;

  // Questionable condition bit positions
  localparam int ISR_QS_POWER = 3;
  localparam int ISR_QS_ALARM = 9;
  localparam int ISR_QS_SENSOR = 10;
  localparam int ISR_QS_BURST = 11;

  // Status byte positions of the summary bits from this block
  localparam int ISR_SB_QUES = 3;
  localparam int ISR_SB_ESB = 5;
  localparam int ISR_SB_OPER = 7;

  // Command codes
  typedef enum logic [4:0] {
    ISR_CMD_NONE = 5'h00,
    ISR_CMD_PPM_WR = 5'h01,
    ISR_CMD_PPM_RD = 5'h02,
    ISR_CMD_SEL_RD = 5'h03,
    ISR_CMD_SEM_WR = 5'h04,
    ISR_CMD_SEM_RD = 5'h05,
    ISR_CMD_FLAG_RD = 5'h06,
    ISR_CMD_OPC = 5'h07,
    ISR_CMD_CLS = 5'h08,
    ISR_CMD_OP_COND_RD = 5'h09,
    ISR_CMD_OP_EVT_RD = 5'h0A,
    ISR_CMD_OP_ENA_WR = 5'h0B,
    ISR_CMD_OP_ENA_RD = 5'h0C,
    ISR_CMD_OP_PTR_WR = 5'h0D,
    ISR_CMD_OP_PTR_RD = 5'h0E,
    ISR_CMD_OP_FALL_WR = 5'h0F,
    ISR_CMD_OP_FALL_RD = 5'h10,
    ISR_CMD_QS_COND_RD = 5'h11,
    ISR_CMD_QS_EVT_RD = 5'h12,
    ISR_CMD_QS_ENA_WR = 5'h13,
    ISR_CMD_QS_ENA_RD = 5'h14,
    ISR_CMD_QS_PTR_WR = 5'h15,
    ISR_CMD_QS_PTR_RD = 5'h16,
    ISR_CMD_QS_FALL_WR = 5'h17,
    ISR_CMD_QS_FALL_RD = 5'h18
  } isr_cmd_t;

  // Reset values
  localparam logic [ISR_SRW-1:0] ISR_PTR_RST = 16'hFFFF;
  localparam logic [ISR_SRW-1:0] ISR_ZERO16 = 16'h0000;
  localparam logic [ISR_SEW-1:0] ISR_ZERO8 = 8'h00;

  // Command request from the message parser
  typedef struct packed {
    logic valid;
    isr_cmd_t code;
    logic [ISR_SRW-1:0] data;
  } isr_req_t;

  // Standard event sources, one-cycle pulses
  typedef struct packed {
    logic query_err;
    logic device_err;
    logic exec_err;
    logic command_err;
    logic local_request;
    logic power_on;
  } isr_sevt_t;

  // Instrument condition levels
  typedef struct packed {
    logic sensor_init;
    logic measuring;
    logic trigger_wait;
    logic battery_powered;
    logic limit_check_active;
    logic sensor_overload;
    logic bargraph_limit;
    logic ext_power_ctrl;
    logic supply_fault;
    logic threshold_alarm;
    logic sensor_fault;
    logic burst_param_conflict;
  } isr_cond_t;

endpackage

// [rtl/isr_status_reg.sv]
// One SCPI status register: condition, filters, event, enable, summary
`timescale 1ns/1ps
module isr_status_reg
  import isr_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] cond_in,
  input wire logic enable_wr_in,
  input wire logic ptr_wr_in,
  input wire logic fall_wr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic event_rd_in,
  output logic [WIDTH-1:0] cond_out,
  output logic [WIDTH-1:0] event_out,
  output logic [WIDTH-1:0] enable_out,
  output logic [WIDTH-1:0] ptr_out,
  output logic [WIDTH-1:0] falling_edge_filter_out,
  output logic summary_out
);

  typedef struct packed {
    logic [WIDTH-1:0] cond;
    logic [WIDTH-1:0] evt;
    logic [WIDTH-1:0] ena;
    logic [WIDTH-1:0] ptr;
    logic [WIDTH-1:0] fall;
  } isr_sr_state_t;

  isr_sr_state_t state;
  isr_sr_state_t next_state;
  logic [WIDTH-1:0] hits;

  always_comb
  begin
    next_state = state;
    next_state.cond = cond_in;
    hits = (cond_in & ~state.cond & state.ptr) | (~cond_in & state.cond & state.fall);
    if (event_rd_in)
    begin
      next_state.evt = hits;
    end
    else
    begin
      next_state.evt = state.evt | hits;
    end
    if (enable_wr_in)
    begin
      next_state.ena = wr_data_in;
    end
    if (ptr_wr_in)
    begin
      next_state.ptr = wr_data_in;
    end
    if (fall_wr_in)
    begin
      next_state.fall = wr_data_in;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      state.cond <= '0;
      state.evt <= '0;
      state.ena <= '0;
      state.ptr <= '1;
      state.fall <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign cond_out = state.cond;
  assign event_out = state.evt;
  assign enable_out = state.ena;
  assign ptr_out = state.ptr;
  assign falling_edge_filter_out = state.fall;
  assign summary_out = |(state.evt & state.ena);

endmodule // isr_status_reg

// [rtl/isr_status_top.sv]
// Top of the instrument status reporting block
`timescale 1ns/1ps
module isr_status_top
  import isr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire isr_req_t req_in,
  input wire isr_sevt_t sevt_in,
  input wire isr_cond_t cond_in,
  input wire logic cmds_idle_in,
  input wire logic [ISR_SEW-1:0] status_byte_in,
  output logic [ISR_SRW-1:0] rsp_data_out,
  output logic rsp_valid_out,
  output logic individual_status_flag_out,
  output logic esb_summary_out,
  output logic oper_summary_out,
  output logic ques_summary_out,
  output logic [ISR_SEW-1:0] status_byte_out
);

  typedef struct packed {
    logic [ISR_SEW-1:0] standard_event_latch;
    logic [ISR_SEW-1:0] standard_event_mask;
    logic [ISR_SEW-1:0] parallel_poll_mask;
    logic opc_pending;
    logic pon_seen;
    logic [ISR_SRW-1:0] rsp_data;
    logic rsp_valid;
  } isr_top_state_t;

  isr_top_state_t state;
  isr_top_state_t next_state;

  logic [ISR_SRW-1:0] op_cond;
  logic [ISR_SRW-1:0] qs_cond;
  logic [ISR_SRW-1:0] op_event;
  logic [ISR_SRW-1:0] op_enable;
  logic [ISR_SRW-1:0] op_ptr;
  logic [ISR_SRW-1:0] op_fall;
  logic [ISR_SRW-1:0] op_cond_q;
  logic [ISR_SRW-1:0] qs_event;
  logic [ISR_SRW-1:0] qs_enable;
  logic [ISR_SRW-1:0] qs_ptr;
  logic [ISR_SRW-1:0] qs_fall;
  logic [ISR_SRW-1:0] qs_cond_q;
  logic op_sum;
  logic qs_sum;
  logic [ISR_SEW-1:0] sbyte;
  logic [ISR_SEW-1:0] sevt_hits;

  // Command decode test, used for every strobe
  function automatic logic is_cmd(input isr_req_t r, input isr_cmd_t c);
    is_cmd = r.valid && (r.code == c);
  endfunction

  function automatic logic [ISR_SRW-1:0] widen8(input logic [ISR_SEW-1:0] v);
    widen8 = {ISR_ZERO8, v};
  endfunction

  // Condition wiring of the operation register
  always_comb
  begin
    op_cond = ISR_ZERO16;
    op_cond[ISR_OP_SETTING] = cond_in.sensor_init;
    op_cond[ISR_OP_MEASURING] = cond_in.measuring;
    op_cond[ISR_OP_TRIGGER_WAIT] = cond_in.trigger_wait;
    op_cond[ISR_OP_BATTERY] = cond_in.battery_powered;
    op_cond[ISR_OP_LIMIT] = cond_in.limit_check_active;
  end

  // Condition wiring of the questionable register
  always_comb
  begin
    qs_cond = ISR_ZERO16;
    qs_cond[ISR_QS_POWER] = cond_in.sensor_overload
      | (cond_in.bargraph_limit & cond_in.ext_power_ctrl)
      | cond_in.supply_fault;
    qs_cond[ISR_QS_ALARM] = cond_in.threshold_alarm;
    qs_cond[ISR_QS_SENSOR] = cond_in.sensor_fault;
    qs_cond[ISR_QS_BURST] = cond_in.burst_param_conflict;
  end

  isr_status_reg #(
    .WIDTH(ISR_SRW)
  ) u_oper (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .cond_in(op_cond),
    .enable_wr_in(is_cmd(req_in, ISR_CMD_OP_ENA_WR)),
    .ptr_wr_in(is_cmd(req_in, ISR_CMD_OP_PTR_WR)),
    .fall_wr_in(is_cmd(req_in, ISR_CMD_OP_FALL_WR)),
    .wr_data_in(req_in.data),
    .event_rd_in(is_cmd(req_in, ISR_CMD_OP_EVT_RD)),
    .cond_out(op_cond_q),
    .event_out(op_event),
    .enable_out(op_enable),
    .ptr_out(op_ptr),
    .falling_edge_filter_out(op_fall),
    .summary_out(op_sum)
  );

  isr_status_reg #(
    .WIDTH(ISR_SRW)
  ) u_ques (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .cond_in(qs_cond),
    .enable_wr_in(is_cmd(req_in, ISR_CMD_QS_ENA_WR)),
    .ptr_wr_in(is_cmd(req_in, ISR_CMD_QS_PTR_WR)),
    .fall_wr_in(is_cmd(req_in, ISR_CMD_QS_FALL_WR)),
    .wr_data_in(req_in.data),
    .event_rd_in(is_cmd(req_in, ISR_CMD_QS_EVT_RD)),
    .cond_out(qs_cond_q),
    .event_out(qs_event),
    .enable_out(qs_enable),
    .ptr_out(qs_ptr),
    .falling_edge_filter_out(qs_fall),
    .summary_out(qs_sum)
  );

  always_comb
  begin
    sbyte = status_byte_in;
    sbyte[ISR_SB_QUES] = qs_sum;
    sbyte[ISR_SB_ESB] = |(state.standard_event_latch & state.standard_event_mask);
    sbyte[ISR_SB_OPER] = op_sum;
  end

  // Standard event sources
  always_comb
  begin
    sevt_hits = ISR_ZERO8;
    // completes once all earlier commands are done
    sevt_hits[ISR_SE_OPC] = (state.opc_pending | is_cmd(req_in, ISR_CMD_OPC)) & cmds_idle_in;
    sevt_hits[ISR_SE_QRY] = sevt_in.query_err;
    sevt_hits[ISR_SE_DEV] = sevt_in.device_err;
    sevt_hits[ISR_SE_EXE] = sevt_in.exec_err;
    sevt_hits[ISR_SE_CMD] = sevt_in.command_err;
    sevt_hits[ISR_SE_USR] = sevt_in.local_request;
    // power on, first cycle after reset too
    sevt_hits[ISR_SE_PON] = sevt_in.power_on | ~state.pon_seen;
  end

  always_comb
  begin
    next_state = state;
    next_state.pon_seen = 1'b1;
    next_state.rsp_valid = 1'b0;
    next_state.opc_pending = (state.opc_pending | is_cmd(req_in, ISR_CMD_OPC))
      & ~cmds_idle_in;
    // latch with read clear, set wins
    if (is_cmd(req_in, ISR_CMD_SEL_RD) || is_cmd(req_in, ISR_CMD_CLS))
    begin
      next_state.standard_event_latch = sevt_hits;
    end
    else
    begin
      next_state.standard_event_latch = state.standard_event_latch | sevt_hits;
    end
    if (is_cmd(req_in, ISR_CMD_SEM_WR))
    begin
      next_state.standard_event_mask = req_in.data[ISR_SEW-1:0];
    end
    if (is_cmd(req_in, ISR_CMD_PPM_WR))
    begin
      next_state.parallel_poll_mask = req_in.data[ISR_SEW-1:0];
    end
    if (req_in.valid)
    begin
      next_state.rsp_valid = 1'b1;
      unique case (req_in.code)
        ISR_CMD_PPM_RD: next_state.rsp_data = widen8(state.parallel_poll_mask);
        ISR_CMD_SEL_RD: next_state.rsp_data = widen8(state.standard_event_latch);
        ISR_CMD_SEM_RD: next_state.rsp_data = widen8(state.standard_event_mask);
        ISR_CMD_FLAG_RD: next_state.rsp_data = widen8({7'h00, individual_status_flag_out});
        ISR_CMD_OP_COND_RD: next_state.rsp_data = op_cond_q;
        ISR_CMD_OP_EVT_RD: next_state.rsp_data = op_event;
        ISR_CMD_OP_ENA_RD: next_state.rsp_data = op_enable;
        ISR_CMD_OP_PTR_RD: next_state.rsp_data = op_ptr;
        ISR_CMD_OP_FALL_RD: next_state.rsp_data = op_fall;
        ISR_CMD_QS_COND_RD: next_state.rsp_data = qs_cond_q;
        ISR_CMD_QS_EVT_RD: next_state.rsp_data = qs_event;
        ISR_CMD_QS_ENA_RD: next_state.rsp_data = qs_enable;
        ISR_CMD_QS_PTR_RD: next_state.rsp_data = qs_ptr;
        ISR_CMD_QS_FALL_RD: next_state.rsp_data = qs_fall;
        default: next_state.rsp_valid = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      state.standard_event_latch <= ISR_ZERO8;
      state.standard_event_mask <= ISR_ZERO8;
      state.parallel_poll_mask <= ISR_ZERO8;
      state.opc_pending <= 1'b0;
      state.pon_seen <= 1'b0;
      state.rsp_data <= ISR_ZERO16;
      state.rsp_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // flag from all eight bits, bit 6 included
  assign individual_status_flag_out = |(sbyte & state.parallel_poll_mask);
  assign rsp_data_out = state.rsp_data;
  assign rsp_valid_out = state.rsp_valid;
  assign esb_summary_out = sbyte[ISR_SB_ESB];
  assign oper_summary_out = op_sum;
  assign ques_summary_out = qs_sum;
  assign status_byte_out = sbyte;

endmodule // isr_status_top

// [tb/isr_ctrl_model.sv]
// Bus controller model issuing status commands
`timescale 1ns/1ps
module isr_ctrl_model
  import isr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic [ISR_SRW-1:0] rsp_data_in,
  input wire logic rsp_valid_in,
  output isr_req_t req_out
);
  logic [ISR_SRW-1:0] last_rsp;
  logic got_rsp;
  initial req_out = '0;
  task automatic issue(input isr_cmd_t code, input logic [ISR_SRW-1:0] data);
    @(posedge clk_sys_in);
    req_out <= '{valid: 1'b1, code: code, data: data};
    @(posedge clk_sys_in);
    req_out <= '{valid: 1'b0, code: ISR_CMD_NONE, data: ~data};
    @(negedge clk_sys_in);
    got_rsp = rsp_valid_in;
    last_rsp = rsp_data_in;
  endtask
endmodule // isr_ctrl_model

// [tb/isr_status_properties.sv]
// Port assertions for the status reporting block
`timescale 1ns/1ps
module isr_status_properties
  import isr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire isr_req_t req_in,
  input wire logic [ISR_SEW-1:0] status_byte_in,
  input wire logic [ISR_SRW-1:0] rsp_data_out,
  input wire logic rsp_valid_out,
  input wire logic individual_status_flag_out,
  input wire logic esb_summary_out,
  input wire logic oper_summary_out,
  input wire logic ques_summary_out,
  input wire logic [ISR_SEW-1:0] status_byte_out
);
  logic [ISR_SEW-1:0] ppm;
  logic is_qry;
  logic is_byte;
  assign is_qry = req_in.valid && (req_in.code inside {5'h02, 5'h03, 5'h05, 5'h06, 5'h09,
    5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h11, 5'h12, 5'h14, 5'h16, 5'h18});
  assign is_byte = req_in.valid && (req_in.code inside {ISR_CMD_PPM_RD, ISR_CMD_SEL_RD,
    ISR_CMD_SEM_RD, ISR_CMD_FLAG_RD});
  // Shadow of the poll mask
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      ppm <= ISR_ZERO8;
    else if (req_in.valid && req_in.code == ISR_CMD_PPM_WR)
      ppm <= req_in.data[ISR_SEW-1:0];
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_query;
    is_qry;
  endsequence
  sequence s_answer;
    rsp_valid_out;
  endsequence
  chk_query_gets_answer: assert property (s_query |=> s_answer)
    else $error("query left without answer");
  chk_answer_has_cause: assert property (s_answer |-> $past(is_qry))
    else $error("answer without query");
  chk_flag_from_mask: assert property (individual_status_flag_out == |(status_byte_out & ppm))
    else $error("status flag differs from masked byte");
  chk_sb_summary_map: assert property (status_byte_out == {oper_summary_out, status_byte_in[6],
    esb_summary_out, status_byte_in[4], ques_summary_out, status_byte_in[2:0]})
    else $error("status byte summary bits wrong");
  chk_mask_readback: assert property (req_in.valid && req_in.code == ISR_CMD_PPM_RD
    |=> rsp_data_out == {8'h00, $past(ppm)})
    else $error("poll mask readback wrong");
  chk_byte_upper_zero: assert property (is_byte |=> rsp_data_out[15:8] == 8'h00)
    else $error("upper answer byte not zero");
  chk_flag_query_bit: assert property (req_in.valid && req_in.code == ISR_CMD_FLAG_RD
    |=> rsp_data_out == {15'h0000, $past(individual_status_flag_out)})
    else $error("flag query answer wrong");
  chk_answer_data_holds: assert property ($past(rst_n_in) && !rsp_valid_out
    |-> $stable(rsp_data_out))
    else $error("answer data changed without query");
endmodule // isr_status_properties

bind isr_status_top isr_status_properties u_isr_status_properties (.clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in), .req_in(req_in), .status_byte_in(status_byte_in),
  .rsp_data_out(rsp_data_out), .rsp_valid_out(rsp_valid_out),
  .individual_status_flag_out(individual_status_flag_out), .esb_summary_out(esb_summary_out),
  .oper_summary_out(oper_summary_out), .ques_summary_out(ques_summary_out),
  .status_byte_out(status_byte_out));

// [tb/test_isr_status_top.sv]
// Self-checking bench for the status reporting block
`timescale 1ns/1ps
module test_isr_status_top;
  import isr_pkg::*;
  logic clk_sys_in, rst_n_in, cmds_idle_in, rsp_valid_out, individual_status_flag_out;
  logic esb_summary_out, oper_summary_out, ques_summary_out;
  isr_req_t req_in;
  isr_sevt_t sevt_in;
  isr_cond_t cond_in;
  logic [ISR_SEW-1:0] status_byte_in, status_byte_out;
  logic [ISR_SRW-1:0] rsp_data_out;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [11:0] cv [12] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h080, 12'h040, 12'h020,
    12'h030, 12'h008, 12'h004, 12'h002, 12'h001};
  logic [15:0] ov [12] = '{16'h0002, 16'h0010, 16'h0020, 16'h0100, 16'h0200, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] qv [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0008,
    16'h0000, 16'h0008, 16'h0008, 16'h0200, 16'h0400, 16'h0800};
  isr_status_top u_isr_status_top (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .req_in(req_in), .sevt_in(sevt_in), .cond_in(cond_in), .cmds_idle_in(cmds_idle_in),
    .status_byte_in(status_byte_in), .rsp_data_out(rsp_data_out), .rsp_valid_out(rsp_valid_out),
    .individual_status_flag_out(individual_status_flag_out), .esb_summary_out(esb_summary_out),
    .oper_summary_out(oper_summary_out), .ques_summary_out(ques_summary_out),
    .status_byte_out(status_byte_out));
  isr_ctrl_model u_isr_ctrl_model (.clk_sys_in(clk_sys_in), .rsp_data_in(rsp_data_out),
    .rsp_valid_in(rsp_valid_out), .req_out(req_in));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input isr_cmd_t c, input logic [15:0] e);
    u_isr_ctrl_model.issue(c, 16'h0000);
    check({u_isr_ctrl_model.got_rsp, u_isr_ctrl_model.last_rsp}, {1'b1, e});
  endtask
  task automatic pulse(input logic [5:0] v);
    @(posedge clk_sys_in);
    sevt_in <= isr_sevt_t'(v);
    @(posedge clk_sys_in);
    sevt_in <= '0;
    @(negedge clk_sys_in);
  endtask
  task automatic end_sim;
    $display("Counts: checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    $display("Watchdog expired");
    end_sim();
  end
  initial
  begin
    rst_n_in = 1'b0;
    sevt_in = '0;
    cond_in = '0;
    cmds_idle_in = 1'b1;
    status_byte_in = 8'h00;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(ISR_CMD_SEL_RD, 16'h0080);
    rd(ISR_CMD_SEL_RD, 16'h0000);
    rd(ISR_CMD_SEM_RD, 16'h0000);
    rd(ISR_CMD_PPM_RD, 16'h0000);
    rd(ISR_CMD_OP_PTR_RD, 16'hFFFF);
    rd(ISR_CMD_QS_FALL_RD, 16'h0000);
    $display("Test reset_values done");
    for (int i = 0; i < 6; i++)
    begin
      pulse(6'h20 >> i);
      rd(ISR_CMD_SEL_RD, 16'h0004 << i);
    end
    $display("Test event_sources done");
    u_isr_ctrl_model.issue(ISR_CMD_SEM_WR, 16'h0004);
    rd(ISR_CMD_SEM_RD, 16'h0004);
    pulse(6'h20);
    check({16'h0000, esb_summary_out}, 17'h00001);
    check({9'h000, status_byte_out}, 17'h00020);
    u_isr_ctrl_model.issue(ISR_CMD_PPM_WR, 16'h0020);
    rd(ISR_CMD_FLAG_RD, 16'h0001);
    rd(ISR_CMD_PPM_RD, 16'h0020);
    @(posedge clk_sys_in);
    status_byte_in <= 8'h40;
    u_isr_ctrl_model.issue(ISR_CMD_PPM_WR, 16'h0040);
    rd(ISR_CMD_FLAG_RD, 16'h0001);
    rd(ISR_CMD_SEL_RD, 16'h0004);
    check({16'h0000, esb_summary_out}, 17'h00000);
    $display("Test masks_and_flag done");
    @(posedge clk_sys_in);
    cmds_idle_in <= 1'b0;
    u_isr_ctrl_model.issue(ISR_CMD_OPC, 16'h0000);
    rd(ISR_CMD_SEL_RD, 16'h0000);
    @(posedge clk_sys_in);
    cmds_idle_in <= 1'b1;
    rd(ISR_CMD_SEL_RD, 16'h0001);
    $display("Test operation_complete done");
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk_sys_in);
      cond_in <= isr_cond_t'(cv[i]);
      rd(ISR_CMD_OP_COND_RD, ov[i]);
      rd(ISR_CMD_QS_COND_RD, qv[i]);
    end
    @(posedge clk_sys_in);
    cond_in <= '0;
    $display("Test conditions done");
    rd(ISR_CMD_OP_EVT_RD, 16'h0332);
    rd(ISR_CMD_QS_EVT_RD, 16'h0E08);
    rd(ISR_CMD_OP_EVT_RD, 16'h0000);
    u_isr_ctrl_model.issue(ISR_CMD_OP_PTR_WR, 16'h0000);
    u_isr_ctrl_model.issue(ISR_CMD_OP_FALL_WR, 16'h0010);
    u_isr_ctrl_model.issue(ISR_CMD_OP_ENA_WR, 16'h0010);
    rd(ISR_CMD_OP_FALL_RD, 16'h0010);
    @(posedge clk_sys_in);
    cond_in <= isr_cond_t'(12'h400);
    rd(ISR_CMD_OP_EVT_RD, 16'h0000);
    @(posedge clk_sys_in);
    cond_in <= '0;
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    check({16'h0000, oper_summary_out}, 17'h00001);
    check({9'h000, status_byte_out}, 17'h000C0);
    rd(ISR_CMD_OP_EVT_RD, 16'h0010);
    rd(ISR_CMD_OP_ENA_RD, 16'h0010);
    check({16'h0000, oper_summary_out}, 17'h00000);
    $display("Test transition_filters done");
    u_isr_ctrl_model.issue(ISR_CMD_QS_PTR_WR, 16'h0800);
    u_isr_ctrl_model.issue(ISR_CMD_QS_FALL_WR, 16'h0200);
    u_isr_ctrl_model.issue(ISR_CMD_QS_ENA_WR, 16'h0A00);
    rd(ISR_CMD_QS_PTR_RD, 16'h0800);
    rd(ISR_CMD_QS_FALL_RD, 16'h0200);
    rd(ISR_CMD_QS_ENA_RD, 16'h0A00);
    // Rising edge lands in the cycle of the event read
    fork
      begin
        @(posedge clk_sys_in);
        cond_in <= isr_cond_t'(12'h001);
      end
      rd(ISR_CMD_QS_EVT_RD, 16'h0000);
    join
    check({16'h0000, ques_summary_out}, 17'h00001);
    check({9'h000, status_byte_out}, 17'h00048);
    @(posedge clk_sys_in);
    cond_in <= isr_cond_t'(12'h004);
    rd(ISR_CMD_QS_EVT_RD, 16'h0800);
    check({16'h0000, ques_summary_out}, 17'h00000);
    @(posedge clk_sys_in);
    cond_in <= '0;
    rd(ISR_CMD_QS_EVT_RD, 16'h0200);
    $display("Test questionable_filters done");
    pulse(6'h08);
    // Clear and read each meet a new event in the same cycle
    fork
      pulse(6'h04);
      u_isr_ctrl_model.issue(ISR_CMD_CLS, 16'h0000);
    join
    fork
      pulse(6'h10);
      rd(ISR_CMD_SEL_RD, 16'h0020);
    join
    rd(ISR_CMD_SEL_RD, 16'h0008);
    $display("Test clear_and_coincide done");
    end_sim();
  end
endmodule // test_isr_status_top
